// ==== design/tag_pkg.sv ====
package tag_pkg;

  // APB register byte addresses
  localparam logic [7:0] REG_CFG0   = 8'h00;
  localparam logic [7:0] REG_CFG1   = 8'h04;
  localparam logic [7:0] REG_STATUS = 8'h08;
  localparam logic [7:0] REG_PWD    = 8'h0c;
  localparam logic [7:0] REG_AUTH   = 8'h10;

  // Primary config byte fields
  localparam int CFG0_PMODE_LO = 0;
  localparam int CFG0_ARB_BIT  = 2;
  localparam int CFG0_SILENT   = 3;
  localparam int CFG0_EXT_EN   = 4;
  localparam int CFG0_TUN_EN   = 5;
  localparam logic [7:0] CFG0_RESET = 8'h00;

  // Harvest config byte fields: vreg in [4:0], rreg in [6:5]
  localparam int CFG1_RREG_LO = 5;
  localparam logic [7:0] CFG1_RESET = 8'h00;
  localparam logic [4:0] VREG_MAX   = 5'h1b;

  // Status bit positions
  localparam int ST_CONFLICT = 0;
  localparam int ST_LOCKED   = 1;
  localparam int ST_AUTH     = 2;
  localparam int ST_SRC_LO   = 3;
  localparam int ST_SILENT   = 5;
  localparam int ST_ABORT    = 6;

  localparam logic [2:0] MAX_FAILS = 3'h7;
  localparam logic [31:0] PWD_RESET = 32'h00000000;

  // Timing
  localparam int CLK_MHZ      = 250;
  localparam int HOLD_NS      = 700000;
  localparam int HOLD_CYCLES  = (HOLD_NS * CLK_MHZ + 999) / 1000;

  typedef enum logic [1:0] {
    SRC_OFF = 2'h0,
    SRC_RF  = 2'h1,
    SRC_EXT = 2'h3
  } supply_src_e;

  typedef struct packed {
    logic [1:0] pmode;
    logic       arb_rf_prio;
    logic       silent_en;
    logic       ext_en;
    logic       tun_en;
  } cfg_s;

  typedef struct packed {
    logic       out_en;
    logic [1:0] rreg;
    logic [4:0] vreg;
  } harvest_s;

endpackage

// ==== design/pin_sync.sv ====
`timescale 1ns/1ns
// Two-flop synchroniser, one per bit
module pin_sync
  import tag_pkg::*;
#(
  parameter int W = 1
) (
  input  wire logic         pclk,
  input  wire logic         presetn,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta_q;

  // Only the second stage is read outside
  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_bit
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          meta_q[i] <= 1'b0;
          q[i]      <= 1'b0;
        end else begin
          meta_q[i] <= d[i];
          q[i]      <= meta_q[i];
        end
      end
    end
  endgenerate
endmodule

// ==== design/harvest_ctrl.sv ====
`timescale 1ns/1ns
// Energy harvesting gate and decode
module harvest_ctrl
  import tag_pkg::*;
(
  input  wire logic     pclk,
  input  wire logic     presetn,
  input  wire cfg_s     cfg,
  input  wire logic [7:0] cfg1,
  output harvest_s      harvest
);
  harvest_s h_d;

  // Mode 1 without a bridging mode forces rreg to zero
  always_comb begin
    h_d.vreg = (cfg1[4:0] > VREG_MAX) ? VREG_MAX : cfg1[4:0];
    h_d.rreg = cfg1[CFG1_RREG_LO +: 2];
    if (cfg.pmode == 2'h1 && !(cfg.ext_en || cfg.tun_en)) begin
      h_d.rreg = 2'h0;
    end
    if (cfg.pmode != 2'h1 && cfg.pmode != 2'h2) begin
      h_d.rreg = 2'h0;
    end
    h_d.out_en = (h_d.rreg != 2'h0);
  end

  // Registered so the analog trims never glitch
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      harvest <= '0;
    end else begin
      harvest <= h_d;
    end
  end
endmodule

// ==== design/tag_power_and_access_control.sv ====
`timescale 1ns/1ns
module tag_power_and_access_control
  import tag_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Asynchronous pins
  input  wire logic        field_power_on_detect,
  input  wire logic        ss_n,
  input  wire logic        ext_supply_ok,
  input  wire logic        ext_supply_present,
  // RF-side requests, same clock
  input  wire logic        rf_wr_req,
  input  wire logic        rf_rd_req,
  input  wire logic        rf_pwd_wr,
  input  wire logic [31:0] rf_pwd_data,
  input  wire logic        rf_prot_access,
  input  wire logic        rf_wr_busy,
  // Host-side EEPROM write, same clock
  input  wire logic        host_wr_req,
  input  wire logic        host_wr_busy,
  // Outputs
  output logic [1:0]       supply_src,
  output logic             rf_nak,
  output logic             rf_grant,
  output logic             host_wr_abort,
  output logic             rf_disable,
  output logic             rf_access_deny,
  output logic             conflict_irq,
  output harvest_s         harvest
);

  logic [3:0] pins_s;
  logic       field_s;
  logic       ss_low_s;
  logic       ext_ok_s;
  logic       ext_pres_s;
  logic       field_prev_q;
  cfg_s       cfg;
  logic [7:0] cfg0_q;
  logic [7:0] cfg1_q;
  logic [31:0] pwd_q;
  logic [2:0] fail_cnt_q;
  logic       auth_q;
  logic       conflict_q;
  logic       abort_q;
  logic [$clog2(HOLD_CYCLES+1)-1:0] hold_cnt_q;
  logic       hold_active;
  logic       apb_wr;
  logic       apb_rd;
  logic       locked;
  logic       field_rise;
  logic       conflict_set;
  logic       abort_set;
  supply_src_e src_d;

  // Pins from outside the clock domain
  pin_sync #(.W(4)) u_sync (
    .pclk    (pclk),
    .presetn (presetn),
    .d       ({field_power_on_detect, ~ss_n, ext_supply_ok, ext_supply_present}),
    .q       (pins_s)
  );
  assign field_s    = pins_s[3];
  assign ss_low_s   = pins_s[2];
  assign ext_ok_s   = pins_s[1];
  assign ext_pres_s = pins_s[0];

  assign cfg.pmode       = cfg0_q[CFG0_PMODE_LO +: 2];
  assign cfg.arb_rf_prio = cfg0_q[CFG0_ARB_BIT];
  assign cfg.silent_en   = cfg0_q[CFG0_SILENT];
  assign cfg.ext_en      = cfg0_q[CFG0_EXT_EN];
  assign cfg.tun_en      = cfg0_q[CFG0_TUN_EN];

  // Zero-wait APB slave
  assign pready  = 1'b1;
  assign pslverr = 1'b0;
  assign apb_wr  = psel && penable && pwrite;
  assign apb_rd  = psel && penable && !pwrite;

  // Configuration registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg0_q <= CFG0_RESET;
      cfg1_q <= CFG1_RESET;
      pwd_q  <= PWD_RESET;
    end else if (apb_wr) begin
      if (paddr == REG_CFG0) begin
        cfg0_q <= pwdata[7:0];
      end
      if (paddr == REG_CFG1) begin
        cfg1_q <= pwdata[7:0];
      end
      if (paddr == REG_PWD) begin
        pwd_q <= pwdata;
      end
    end
  end

  // Read mux; unmapped reads return zero
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= '0;
    end else if (psel && !penable && !pwrite) begin
      case (paddr)
        REG_CFG0: prdata <= {24'h000000, cfg0_q};
        REG_CFG1: prdata <= {24'h000000, cfg1_q};
        REG_STATUS: prdata <= {25'h0, abort_q, rf_disable, supply_src, auth_q, locked, conflict_q};
        REG_AUTH: prdata <= {29'h0, fail_cnt_q};
        default: prdata <= '0;
      endcase
    end
  end

  // Release hold of the external switch after select rises
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hold_cnt_q <= '0;
    end else if (ss_low_s || host_wr_busy) begin
      hold_cnt_q <= ($clog2(HOLD_CYCLES+1))'(HOLD_CYCLES);
    end else if (hold_cnt_q != '0) begin
      hold_cnt_q <= hold_cnt_q - 1'b1;
    end
  end
  assign hold_active = ss_low_s || host_wr_busy || (hold_cnt_q != '0);

  // Supply source selection; the field wins when present in mode 0
  always_comb begin
    src_d = SRC_OFF;
    case (cfg.pmode)
      2'h0: begin
        if (field_s) begin
          src_d = SRC_RF;
        end else if (hold_active) begin
          src_d = SRC_EXT;
        end else begin
          src_d = SRC_OFF;
        end
      end
      2'h1: begin
        src_d = field_s ? SRC_RF : SRC_OFF;
      end
      2'h2, 2'h3: begin
        if (ext_pres_s || hold_active) begin
          src_d = SRC_EXT;
        end else begin
          src_d = field_s ? SRC_RF : SRC_OFF;
        end
      end
      default: src_d = SRC_OFF;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      supply_src <= SRC_OFF;
    end else begin
      supply_src <= src_d;
    end
  end

  // Silent mode disables the RF side while the external supply is not ok
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rf_disable <= 1'b0;
    end else begin
      rf_disable <= cfg.silent_en && !ext_ok_s;
    end
  end

  // Field edge detect on the synchronised level
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      field_prev_q <= 1'b0;
    end else begin
      field_prev_q <= field_s;
    end
  end
  assign field_rise = field_s && !field_prev_q;

  // Arbitration events
  assign abort_set = cfg.arb_rf_prio && host_wr_busy && !rf_disable
                     && (field_rise || rf_wr_req || rf_rd_req);
  assign conflict_set = abort_set
                        || (!cfg.arb_rf_prio && host_wr_req && rf_wr_busy);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rf_nak        <= 1'b0;
      rf_grant      <= 1'b0;
      host_wr_abort <= 1'b0;
    end else begin
      rf_nak        <= rf_wr_req && !rf_disable && !cfg.arb_rf_prio && host_wr_busy;
      rf_grant      <= (rf_wr_req || rf_rd_req) && !rf_disable
                       && (cfg.arb_rf_prio || !host_wr_busy || rf_rd_req);
      host_wr_abort <= abort_set;
    end
  end

  // Sticky flags; a set in the clearing cycle wins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      conflict_q <= 1'b0;
      abort_q    <= 1'b0;
    end else begin
      if (conflict_set) begin
        conflict_q <= 1'b1;
      end else if (apb_rd && paddr == REG_STATUS) begin
        conflict_q <= 1'b0;
      end
      if (abort_set) begin
        abort_q <= 1'b1;
      end else if (apb_rd && paddr == REG_STATUS) begin
        abort_q <= 1'b0;
      end
    end
  end
  assign conflict_irq = conflict_q;

  // Password check with failure lockout; host writes to AUTH load the count from pwdata[2:0]
  assign locked = (fail_cnt_q == MAX_FAILS);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fail_cnt_q <= '0;
      auth_q     <= 1'b0;
    end else if (apb_wr && paddr == REG_AUTH) begin
      fail_cnt_q <= pwdata[2:0];
      auth_q     <= 1'b0;
    end else if (rf_pwd_wr && !rf_disable && !locked) begin
      if (rf_pwd_data == pwd_q) begin
        auth_q <= 1'b1;
      end else begin
        fail_cnt_q <= fail_cnt_q + 1'b1;
      end
    end
  end

  // Protection applies to RF only; host path never sees it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rf_access_deny <= 1'b0;
    end else begin
      rf_access_deny <= rf_prot_access && !auth_q;
    end
  end

  harvest_ctrl u_harvest (
    .pclk    (pclk),
    .presetn (presetn),
    .cfg     (cfg),
    .cfg1    (cfg1_q),
    .harvest (harvest)
  );

  // Assertions
  sequence s_host_busy_rf;
    host_wr_busy && cfg.arb_rf_prio && !rf_disable && (rf_wr_req || rf_rd_req);
  endsequence
  // Field arrival during a host write under RF priority
  sequence s_host_busy_field;
    host_wr_busy && cfg.arb_rf_prio && !rf_disable && field_rise;
  endsequence

  a_mode0_off: assert property (@(posedge pclk) disable iff (!presetn)
    (cfg.pmode == 2'h0 && !field_s && !hold_active) |=> supply_src == SRC_OFF)
    else $error("core supply not off");
  a_ext_select: assert property (@(posedge pclk) disable iff (!presetn)
    (cfg.pmode == 2'h0 && !field_s && ss_low_s) |=> supply_src == SRC_EXT)
    else $error("external supply not selected");
  a_write_hold: assert property (@(posedge pclk) disable iff (!presetn)
    host_wr_busy |=> hold_cnt_q != '0)
    else $error("hold dropped during host write");
  a_modes_ext: assert property (@(posedge pclk) disable iff (!presetn)
    (cfg.pmode[1] && ext_pres_s) |=> supply_src == SRC_EXT)
    else $error("external supply lost in mode 2 or 3");
  a_nak_mode0: assert property (@(posedge pclk) disable iff (!presetn)
    (rf_wr_req && !rf_disable && !cfg.arb_rf_prio && host_wr_busy) |=> rf_nak && !rf_grant)
    else $error("no NAK on write conflict");
  a_abort_prio: assert property (@(posedge pclk) disable iff (!presetn)
    s_host_busy_rf |=> host_wr_abort ##0 conflict_q)
    else $error("host write not aborted");
  a_conflict_hold: assert property (@(posedge pclk) disable iff (!presetn)
    (conflict_q && !(apb_rd && paddr == REG_STATUS)) |=> conflict_q)
    else $error("conflict flag cleared early");
  a_silent_rf: assert property (@(posedge pclk) disable iff (!presetn)
    rf_disable |=> !rf_grant && !rf_nak)
    else $error("RF answered while silent");
  a_lockout: assert property (@(posedge pclk) disable iff (!presetn)
    (locked && !(apb_wr && paddr == REG_AUTH)) |=> locked && $stable(auth_q))
    else $error("lockout broken");
  a_harvest_gate: assert property (@(posedge pclk) disable iff (!presetn)
    (cfg.pmode == 2'h0 || cfg.pmode == 2'h3) |=> !harvest.out_en)
    else $error("harvest outside modes 1 and 2");
  a_mode1_rreg: assert property (@(posedge pclk) disable iff (!presetn)
    (cfg.pmode == 2'h1 && !cfg.ext_en && !cfg.tun_en) |=> harvest.rreg == 2'h0)
    else $error("resistance not forced to zero");
  a_field_abort: assert property (@(posedge pclk) disable iff (!presetn)
    s_host_busy_field |=> host_wr_abort && conflict_q)
    else $error("host write not aborted on field arrival");
  a_host_conflict: assert property (@(posedge pclk) disable iff (!presetn)
    (!cfg.arb_rf_prio && host_wr_req && rf_wr_busy) |=> conflict_q)
    else $error("conflict not flagged");
  a_hold_reload: assert property (@(posedge pclk) disable iff (!presetn)
    $fell(ss_low_s) |-> hold_cnt_q == HOLD_CYCLES)
    else $error("hold not restarted on release");
  a_deny_unauth: assert property (@(posedge pclk) disable iff (!presetn)
    (rf_prot_access && !auth_q) |=> rf_access_deny)
    else $error("protected access not denied");
  a_pwd_accept: assert property (@(posedge pclk) disable iff (!presetn)
    (rf_pwd_wr && !rf_disable && !locked && rf_pwd_data == pwd_q && !(apb_wr && paddr == REG_AUTH)) |=> auth_q)
    else $error("password not accepted");
endmodule

// ==== tb/host_model.sv ====
`timescale 1ns/1ns
// Host controller seen from the tag: select line and EEPROM write traffic
module host_model (
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic select_cmd,
  input  wire logic write_cmd,
  input  wire logic host_wr_abort,
  output logic      ss_n,
  output logic      host_wr_req,
  output logic      host_wr_busy
);
  logic wr_q;
  logic retry_q;

  // No serial clock is modelled, so no edge can come before init ends
  assign ss_n = !select_cmd;

  // Only EEPROM writes are issued; an aborted write is issued again
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wr_q         <= 1'b0;
      retry_q      <= 1'b0;
      host_wr_req  <= 1'b0;
      host_wr_busy <= 1'b0;
    end else begin
      wr_q         <= write_cmd;
      retry_q      <= host_wr_abort && write_cmd;
      host_wr_req  <= (write_cmd && !wr_q) || retry_q;
      host_wr_busy <= write_cmd && !host_wr_abort; // Busy drops for one cycle after an abort
    end
  end
endmodule

// ==== tb/tag_power_and_access_control_tb.sv ====
`timescale 1ns/1ns
module tag_power_and_access_control_tb
  import tag_pkg::*;
;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rf_pwd_data, rd;
  logic        field, ss_n, ext_ok, ext_present, rf_wr_req, rf_rd_req, rf_pwd_wr;
  logic        rf_prot_access, rf_wr_busy, host_wr_req, host_wr_busy, select_cmd, write_cmd;
  logic        rf_nak, rf_grant, host_wr_abort, rf_disable, rf_access_deny, conflict_irq, abort_seen, abort_clr;
  logic [1:0]  supply_src, ans;
  harvest_s    harvest;
  int          mismatches, comparisons;
  // Harvest cases: primary config, harvest config, mask, expected
  localparam logic [7:0] HV_C0 [7] = '{8'h01, 8'h11, 8'h21, 8'h02, 8'h02, 8'h00, 8'h03};
  localparam logic [7:0] HV_C1 [7] = '{8'h45, 8'h45, 8'h3f, 8'h60, 8'h1b, 8'h45, 8'h45};
  localparam logic [7:0] HV_MK [7] = '{8'he0, 8'hff, 8'hff, 8'hff, 8'he0, 8'h80, 8'h80};
  localparam logic [7:0] HV_EX [7] = '{8'h00, 8'hc5, 8'hbb, 8'he0, 8'h00, 8'h00, 8'h00};

  tag_power_and_access_control u_tag_power_and_access_control (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .field_power_on_detect(field), .ss_n(ss_n), .ext_supply_ok(ext_ok),
    .ext_supply_present(ext_present), .rf_wr_req(rf_wr_req), .rf_rd_req(rf_rd_req),
    .rf_pwd_wr(rf_pwd_wr), .rf_pwd_data(rf_pwd_data), .rf_prot_access(rf_prot_access),
    .rf_wr_busy(rf_wr_busy), .host_wr_req(host_wr_req), .host_wr_busy(host_wr_busy),
    .supply_src(supply_src), .rf_nak(rf_nak), .rf_grant(rf_grant), .host_wr_abort(host_wr_abort),
    .rf_disable(rf_disable), .rf_access_deny(rf_access_deny), .conflict_irq(conflict_irq),
    .harvest(harvest)
  );

  host_model u_host_model (
    .pclk(pclk), .presetn(presetn), .select_cmd(select_cmd), .write_cmd(write_cmd),
    .host_wr_abort(host_wr_abort), .ss_n(ss_n), .host_wr_req(host_wr_req), .host_wr_busy(host_wr_busy)
  );

  // Clock
  initial begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end

  // Abort is a one-cycle pulse after a slow pin, so it is caught here
  // Only this process writes the catch flag; the test asks for a clear
  always @(posedge pclk) begin
    if (abort_clr) begin
      abort_seen <= 1'b0;
    end else if (host_wr_abort === 1'b1) begin
      abort_seen <= 1'b1;
    end
  end

  task automatic summarize();
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      mismatches++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge pclk);
  endtask

  // One APB transfer; waits on pready, only the watchdog ends a hang
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    @(posedge pclk);
    psel    <= 1'b1;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    q = prdata;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    apb(1'b1, a, d, q);
  endtask

  // RF request pulse; returns grant and nak one cycle later
  task automatic rf_req(input logic rd_kind);
    @(posedge pclk);
    rf_wr_req <= !rd_kind;
    rf_rd_req <= rd_kind;
    @(posedge pclk);
    rf_wr_req <= 1'b0;
    rf_rd_req <= 1'b0;
    #1 ans = {rf_grant, rf_nak};
  endtask

  task automatic pwd_try(input logic [31:0] d);
    @(posedge pclk);
    rf_pwd_wr   <= 1'b1;
    rf_pwd_data <= d;
    @(posedge pclk);
    rf_pwd_wr   <= 1'b0;
    @(posedge pclk);
  endtask

  // Watchdog well beyond the roughly 1300 cycles the tests need
  initial begin
    #80000;
    mismatches++;
    summarize();
  end

  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata, rf_pwd_data} = '0;
    {field, rf_wr_req, rf_rd_req, rf_pwd_wr, rf_prot_access, rf_wr_busy} = '0;
    {select_cmd, write_cmd, ext_present} = '0;
    ext_ok    = 1'b1;
    abort_clr = 1'b1;
    tick(4);
    presetn <= 1'b1;
    #1 check("supply", supply_src, SRC_OFF);
    apb(1'b0, REG_CFG0, 0, rd);
    check("cfg0 reset", rd, CFG0_RESET);
    apb(1'b0, 8'h14, 0, rd);
    check("unmapped", rd, 0);
    check("pslverr", pslverr, 0);
    wr(REG_CFG0, 32'h15);
    apb(1'b0, REG_CFG0, 0, rd);
    check("cfg0", rd[5:0], 6'h15);
    // Mode 2 follows the external supply before any select traffic starts the hold
    wr(REG_CFG0, 32'h02);
    ext_present <= 1'b1;
    tick(6);
    #1 check("supply", supply_src, SRC_EXT);
    tick(1);
    ext_present <= 1'b0;
    tick(6);
    #1 check("supply", supply_src, SRC_OFF);
    // Supply source in mode 0
    wr(REG_CFG0, 32'h0);
    select_cmd <= 1'b1;
    tick(6);
    #1 check("supply", supply_src, SRC_EXT);
    tick(1);
    select_cmd <= 1'b0;
    tick(1000);
    #1 check("supply hold", supply_src, SRC_EXT);
    tick(1);
    field <= 1'b1;
    tick(6);
    #1 check("supply", supply_src, SRC_RF);
    tick(1);
    select_cmd <= 1'b1;
    field      <= 1'b0;
    tick(6);
    #1 check("supply", supply_src, SRC_EXT);
    tick(1);
    select_cmd <= 1'b0;
    // Harvest gating and decode
    for (int i = 0; i < 7; i++) begin
      wr(REG_CFG0, {24'h0, HV_C0[i]});
      wr(REG_CFG1, {24'h0, HV_C1[i]});
      tick(4);
      #1 check("harvest", harvest & HV_MK[i], HV_EX[i]);
    end
    // First come first served
    wr(REG_CFG0, 32'h0);
    write_cmd <= 1'b1;
    tick(3);
    rf_req(1'b0);
    check("rf answer", ans, 2'b01);
    tick(1);
    write_cmd  <= 1'b0;
    rf_wr_busy <= 1'b1;
    tick(3);
    rf_req(1'b0);
    check("rf answer", ans, 2'b10);
    tick(1);
    write_cmd <= 1'b1;
    tick(4);
    #1 check("conflict", conflict_irq, 1);
    tick(1);
    write_cmd  <= 1'b0;
    rf_wr_busy <= 1'b0;
    apb(1'b0, REG_STATUS, 0, rd);
    check("status conflict", rd[0], 1);
    apb(1'b0, REG_STATUS, 0, rd);
    check("status conflict", rd[0], 0);
    // RF priority: field arrival, then RF read
    wr(REG_CFG0, 32'h04);
    write_cmd  <= 1'b1;
    tick(3);
    abort_clr  <= 1'b0;
    field      <= 1'b1;
    tick(8);
    #1 check("abort", abort_seen, 1);
    tick(1);
    write_cmd <= 1'b0;
    tick(3);
    apb(1'b0, REG_STATUS, 0, rd);
    check("status", {rd[6], rd[0]}, 2'b11);
    write_cmd <= 1'b1;
    tick(3);
    rf_req(1'b1);
    check("abort", host_wr_abort, 1);
    check("conflict", conflict_irq, 1);
    tick(1);
    write_cmd <= 1'b0;
    // Silent mode
    wr(REG_CFG0, 32'h08);
    ext_ok <= 1'b0;
    tick(5);
    #1 check("rf off", rf_disable, 1);
    rf_req(1'b0);
    check("rf answer", ans, 2'b00);
    tick(1);
    ext_ok <= 1'b1;
    tick(5);
    #1 check("rf off", rf_disable, 0);
    // Password and lockout
    wr(REG_CFG0, 32'h0);
    wr(REG_PWD, 32'h5a3c96e1);
    rf_prot_access <= 1'b1;
    tick(3);
    #1 check("deny", rf_access_deny, 1);
    apb(1'b0, REG_CFG1, 0, rd);
    check("host read", rd[6:0], 7'h45);
    pwd_try(32'h5a3c96e1);
    tick(2);
    #1 check("deny", rf_access_deny, 0);
    wr(REG_AUTH, 32'h0);
    for (int i = 1; i <= 7; i++) begin
      pwd_try(32'h0);
      apb(1'b0, REG_STATUS, 0, rd);
      check("locked", rd[2:1], {1'b0, i == 7});
    end
    pwd_try(32'h5a3c96e1);
    apb(1'b0, REG_STATUS, 0, rd);
    check("locked", rd[2:1], 2'b01);
    apb(1'b0, REG_AUTH, 0, rd);
    check("fail count", rd[2:0], MAX_FAILS);
    summarize();
  end
endmodule
